/* File: shared/cfg_loader_pkg.sv */
// Constants shared by the configuration download and update controller.
// Assumes a 100 MHz core clock and byte-wide serial bus transactions.
package cfg_loader_pkg;

  // Clock rate and timing.
  localparam int CLK_FREQ_MHZ = 100;
  localparam int SE_LOAD_DELAY_NS = 500000;
  localparam int SE_LOAD_DELAY_CYCLES = (SE_LOAD_DELAY_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int SE_FETCH_NS = 10000;
  localparam int SE_FETCH_CYCLES = (SE_FETCH_NS * CLK_FREQ_MHZ) / 1000;

  // Configuration latch space, pages 0 to 6 of 32 bytes each.
  localparam int PAGE_BYTES = 32;
  localparam int CFG_PAGES = 7;
  localparam int CFG_BYTES = CFG_PAGES * PAGE_BYTES;
  localparam logic [7:0] CFG_LAST_ADDR = 8'hdf;

  // Nonvolatile store: two 512-byte cells, configuration first.
  localparam int NV_AW = 10;
  localparam int NV_BYTES = 1024;
  localparam logic [NV_AW-1:0] SE_BASE = 10'h200;
  localparam int SE_WORD_BYTES = 8;
  localparam logic [5:0] SE_LAST_STATE = 6'h3e;

  // Register offsets and command codes.
  localparam logic [7:0] ADDR_UPDATE_CONTROL = 8'h90;
  localparam logic [7:0] ADDR_USER_DOWNLOAD = 8'hd8;
  localparam logic [7:0] NV_PREFIX_FIRST = 8'hf8;
  localparam logic [7:0] NV_PREFIX_LAST = 8'hfb;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'hfe;

  // Field positions of the update control and user download registers.
  localparam int UPD_TRANSPARENT_BIT = 0;
  localparam int UPD_PULSE_BIT = 1;
  localparam int UPD_ERASE_EN_BIT = 2;
  localparam int UDL_START_BIT = 0;

  // Reset values.
  localparam logic [7:0] UPDATE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] USER_DOWNLOAD_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

endpackage

/* File: design/nv_byte_store.sv */
// Byte-wide nonvolatile store model with one shared port and registered read data.
// Assumes one access per cycle; contents survive the core reset.
`timescale 1ns/1ps
module nv_byte_store
  import cfg_loader_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [NV_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [NV_BYTES];

  // An unprogrammed store reads as erased.
  initial begin
    for (int i = 0; i < NV_BYTES; i++) begin
      mem[i] = ERASED_BYTE;
    end
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end

endmodule

/* File: design/config_download_update_ctrl.sv */
// Configuration download and update controller with double-buffered latches.
// Assumes a serial bus front end that delivers start, byte and read strobes on clk,
// and an asynchronous undervoltage lockout release level from the supply monitor.
//
// Functional notes
// - Each setting has two latches; the first side loads before the second, or in the same cycle when update bit 0 is high.
// - Power-up download starts only after the supply leaves undervoltage lockout.
// - Download fills all first latches, then copies all to second latches at once.
// - Half a millisecond after the power-up download, the first state word loads into the engine; a user download does not reload it.
// - Bus accesses before power-up download completes are answered with not-acknowledge.
// - Update bit 0 high keeps both latch sides open; writes act at once.
// - Update bit 0 low makes writes reach only the first latch side.
// - Writing 1 to update bit 1 copies all first latches to second latches.
// - Nonvolatile changes leave the running setup alone until a reload is commanded.
// - Page erase sets a page to all ones only when erase enable is high.
// - Engine store is 512 bytes: 63 usable 64-bit states, one reserved.
// - Next state word is fetched when conditions are met, taking about 10 us.
// - First byte of each write is stored in the register pointer.
// - User download bit 0 reloads configuration pages 0 to 6 into the latches.
// - Erase enable is bit 2 of the update control register at 0x90.
`timescale 1ns/1ps
module config_download_update_ctrl
  import cfg_loader_pkg::*;
#(
  parameter int SE_DELAY_CYCLES = SE_LOAD_DELAY_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic bus_start,
  input wire logic bus_wbyte_valid,
  input wire logic [7:0] bus_wbyte,
  input wire logic bus_rd_req,
  input wire logic se_advance,
  output logic bus_ack_valid,
  output logic bus_ack,
  output logic bus_rd_valid,
  output logic [7:0] bus_rdata,
  output logic download_done,
  output logic [CFG_BYTES*8-1:0] active_cfg,
  output logic [63:0] se_state_word,
  output logic [5:0] se_state_index
);

  typedef enum logic [2:0] {
    ST_WAIT_SUPPLY, ST_DL_READ, ST_DL_XFER, ST_SE_WAIT, ST_SE_FETCH, ST_RUN, ST_ERASE
  } ctrl_state_t;

  function automatic logic is_nv(input logic [7:0] p);
    return (p >= NV_PREFIX_FIRST) && (p <= NV_PREFIX_LAST);
  endfunction

  ctrl_state_t state_reg;
  logic supply_meta_reg, supply_sync_reg;
  logic boot_reg;
  logic [15:0] cnt_reg;
  logic [8:0] idx_reg;
  logic rd_vld_reg;
  logic [8:0] rd_idx_reg;
  logic [63:0] se_word_reg;
  logic [CFG_BYTES*8-1:0] latch_a_reg;
  logic [7:0] ptr_reg, nv_hi_reg, nv_lo_reg;
  logic [1:0] byte_cnt_reg;
  logic transparent_reg, erase_en_reg, upd_pulse_reg, udl_req_reg, erase_req_reg;
  logic nv_rd_pend_reg;
  logic mem_we;
  logic [NV_AW-1:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic running, data_phase, ram_we, nv_we;
  logic [NV_AW-1:0] nv_addr;

  assign running = (state_reg == ST_RUN);
  assign data_phase = bus_wbyte_valid && running && (byte_cnt_reg != 2'd0);
  assign nv_addr = {nv_hi_reg[1:0], nv_lo_reg};
  assign nv_we = data_phase && is_nv(ptr_reg) && (byte_cnt_reg == 2'd2);
  assign ram_we = data_phase && !is_nv(ptr_reg) && (ptr_reg <= CFG_LAST_ADDR) &&
                  (ptr_reg != ADDR_UPDATE_CONTROL) && (ptr_reg != ADDR_USER_DOWNLOAD);

  // The lockout release comes from the analog supply monitor.
  always_ff @(posedge clk) begin
    if (rst) begin
      supply_meta_reg <= 1'b0;
      supply_sync_reg <= 1'b0;
    end else begin
      supply_meta_reg <= supply_ok;
      supply_sync_reg <= supply_meta_reg;
    end
  end

  // One shared store port: download, engine fetch, bus access and erase take turns.
  always_comb begin
    mem_we = 1'b0;
    mem_addr = nv_addr;
    mem_wdata = bus_wbyte;
    unique case (state_reg)
      ST_DL_READ: mem_addr = NV_AW'(idx_reg);
      ST_SE_FETCH: mem_addr = SE_BASE + NV_AW'({se_state_index, idx_reg[2:0]});
      ST_ERASE: begin
        mem_we = 1'b1;
        mem_addr = {nv_addr[NV_AW-1:5], idx_reg[4:0]};
        mem_wdata = ERASED_BYTE;
      end
      ST_RUN: mem_we = nv_we;
      default: mem_we = 1'b0;
    endcase
  end

  nv_byte_store u_store (
    .clk(clk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // Sequencing of download, engine start, fetches and erase.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_WAIT_SUPPLY;
      boot_reg <= 1'b1;
      cnt_reg <= 16'h0000;
      idx_reg <= 9'h000;
      rd_vld_reg <= 1'b0;
      rd_idx_reg <= 9'h000;
      download_done <= 1'b0;
      se_state_index <= 6'h00;
    end else begin
      rd_vld_reg <= 1'b0;
      unique case (state_reg)
        ST_WAIT_SUPPLY: begin
          idx_reg <= 9'h000;
          if (supply_sync_reg) begin
            state_reg <= ST_DL_READ;
          end
        end
        ST_DL_READ: begin
          if (idx_reg < 9'(CFG_BYTES)) begin
            rd_vld_reg <= 1'b1;
            rd_idx_reg <= idx_reg;
            idx_reg <= idx_reg + 9'h001;
          end else if (!rd_vld_reg) begin
            state_reg <= ST_DL_XFER;
          end
        end
        ST_DL_XFER: begin
          download_done <= 1'b1;
          cnt_reg <= 16'h0000;
          idx_reg <= 9'h000;
          state_reg <= boot_reg ? ST_SE_WAIT : ST_RUN;
        end
        ST_SE_WAIT: begin
          if (cnt_reg == 16'(SE_DELAY_CYCLES - 1)) begin
            cnt_reg <= 16'h0000;
            boot_reg <= 1'b0;
            state_reg <= ST_SE_FETCH;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        ST_SE_FETCH: begin
          if (idx_reg < 9'(SE_WORD_BYTES)) begin
            rd_vld_reg <= 1'b1;
            rd_idx_reg <= idx_reg;
            idx_reg <= idx_reg + 9'h001;
          end
          if (cnt_reg == 16'(SE_FETCH_CYCLES - 1)) begin
            state_reg <= ST_RUN;
          end else begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        ST_RUN: begin
          cnt_reg <= 16'h0000;
          idx_reg <= 9'h000;
          if (udl_req_reg) begin
            state_reg <= ST_DL_READ;
          end else if (erase_req_reg) begin
            state_reg <= ST_ERASE;
          end else if (se_advance) begin
            se_state_index <= (se_state_index == SE_LAST_STATE) ? 6'h00 :
                              se_state_index + 6'h01;
            state_reg <= ST_SE_FETCH;
          end
        end
        ST_ERASE: begin
          idx_reg <= idx_reg + 9'h001;
          if (idx_reg == 9'(PAGE_BYTES - 1)) begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Engine state word, assembled low byte first and handed over at fetch end.
  always_ff @(posedge clk) begin
    if (rst) begin
      se_word_reg <= 64'h0;
      se_state_word <= 64'h0;
    end else begin
      if (rd_vld_reg && (state_reg == ST_SE_FETCH)) begin
        se_word_reg[rd_idx_reg[2:0]*8 +: 8] <= mem_rdata;
      end
      if ((state_reg == ST_SE_FETCH) && (cnt_reg == 16'(SE_FETCH_CYCLES - 1))) begin
        se_state_word <= se_word_reg;
      end
    end
  end

  // Latch pairs: the second side takes data already in the first side, or the bus byte in the same cycle when update bit 0 is high.
  always_ff @(posedge clk) begin
    if (rst) begin
      latch_a_reg <= '0;
      active_cfg <= '0;
    end else begin
      if (rd_vld_reg && (state_reg == ST_DL_READ)) begin
        latch_a_reg[rd_idx_reg*8 +: 8] <= mem_rdata;
      end
      if (ram_we) begin
        latch_a_reg[ptr_reg*8 +: 8] <= bus_wbyte;
      end
      if ((state_reg == ST_DL_XFER) || upd_pulse_reg) begin
        active_cfg <= latch_a_reg;
      end else if (ram_we && transparent_reg) begin
        active_cfg[ptr_reg*8 +: 8] <= bus_wbyte;
      end
    end
  end

  // Serial bus register access: pointer, control bits, acknowledge and read data.
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg <= 8'h00;
      nv_hi_reg <= NV_PREFIX_FIRST;
      nv_lo_reg <= 8'h00;
      byte_cnt_reg <= 2'd0;
      transparent_reg <= UPDATE_CONTROL_RESET[UPD_TRANSPARENT_BIT];
      upd_pulse_reg <= UPDATE_CONTROL_RESET[UPD_PULSE_BIT];
      erase_en_reg <= UPDATE_CONTROL_RESET[UPD_ERASE_EN_BIT];
      udl_req_reg <= USER_DOWNLOAD_RESET[UDL_START_BIT];
      erase_req_reg <= 1'b0;
      nv_rd_pend_reg <= 1'b0;
      bus_ack_valid <= 1'b0;
      bus_ack <= 1'b0;
      bus_rd_valid <= 1'b0;
      bus_rdata <= 8'h00;
    end else begin
      bus_ack_valid <= bus_start || bus_wbyte_valid;
      bus_ack <= bus_start ? download_done : (bus_wbyte_valid && running);
      bus_rd_valid <= 1'b0;
      nv_rd_pend_reg <= 1'b0;
      upd_pulse_reg <= 1'b0;
      if (state_reg == ST_DL_READ) begin
        udl_req_reg <= 1'b0;
      end
      if (state_reg == ST_ERASE) begin
        erase_req_reg <= 1'b0;
      end
      if (bus_start) begin
        byte_cnt_reg <= 2'd0;
      end else if (bus_wbyte_valid && running) begin
        if (byte_cnt_reg != 2'd3) begin
          byte_cnt_reg <= byte_cnt_reg + 2'd1;
        end
        if (byte_cnt_reg == 2'd0) begin
          ptr_reg <= bus_wbyte;
          if ((bus_wbyte == CMD_PAGE_ERASE) && erase_en_reg) begin
            erase_req_reg <= 1'b1;
          end
        end else if ((byte_cnt_reg == 2'd1) && is_nv(ptr_reg)) begin
          nv_hi_reg <= ptr_reg;
          nv_lo_reg <= bus_wbyte;
        end else if (ptr_reg == ADDR_UPDATE_CONTROL) begin
          transparent_reg <= bus_wbyte[UPD_TRANSPARENT_BIT];
          upd_pulse_reg <= bus_wbyte[UPD_PULSE_BIT];
          erase_en_reg <= bus_wbyte[UPD_ERASE_EN_BIT];
        end else if ((ptr_reg == ADDR_USER_DOWNLOAD) && bus_wbyte[UDL_START_BIT]) begin
          udl_req_reg <= 1'b1;
        end
      end
      if (bus_rd_req) begin
        if (!running) begin
          bus_rd_valid <= 1'b1;
          bus_rdata <= ERASED_BYTE;
        end else if (is_nv(ptr_reg)) begin
          nv_rd_pend_reg <= 1'b1;
        end else begin
          bus_rd_valid <= 1'b1;
          if (ptr_reg == ADDR_UPDATE_CONTROL) begin
            bus_rdata <= {5'b00000, erase_en_reg, upd_pulse_reg, transparent_reg};
          end else if (ptr_reg == ADDR_USER_DOWNLOAD) begin
            bus_rdata <= {7'b0000000, udl_req_reg};
          end else if (ptr_reg <= CFG_LAST_ADDR) begin
            bus_rdata <= latch_a_reg[ptr_reg*8 +: 8];
          end else begin
            bus_rdata <= 8'h00;
          end
        end
      end
      if (nv_rd_pend_reg) begin
        bus_rd_valid <= 1'b1;
        bus_rdata <= mem_rdata;
      end
    end
  end

endmodule

/* File: verif/cfg_loader_asserts.sv */
// Port checker for the configuration download and update controller.
// Sees only the top module's ports; bound to every instance below.
`timescale 1ns/1ps
module cfg_loader_asserts
  import cfg_loader_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic bus_start,
  input wire logic bus_rd_req,
  input wire logic bus_ack_valid,
  input wire logic bus_ack,
  input wire logic bus_rd_valid,
  input wire logic download_done,
  input wire logic [CFG_BYTES*8-1:0] active_cfg,
  input wire logic [5:0] se_state_index
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  property p_ans; bus_start |=> bus_ack_valid; endproperty
  a_ans: assert property (p_ans) else $error("start not answered");
  property p_nack; bus_start && !download_done |=> !bus_ack; endproperty
  a_nack: assert property (p_nack) else $error("early start acked");
  property p_ack; bus_start && download_done |=> bus_ack; endproperty
  a_ack: assert property (p_ack) else $error("late start refused");
  property p_sticky; download_done |=> download_done; endproperty
  a_sticky: assert property (p_sticky) else $error("done dropped");
  property p_held; !download_done |-> active_cfg == '0; endproperty
  a_held: assert property (p_held) else $error("active set early");
  property p_undervoltage_lockout; $rose(download_done) |-> $past(supply_ok, 200); endproperty
  a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("download w/o supply");
  property p_rd; bus_rd_req |-> ##[1:2] bus_rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_idx;
    $changed(se_state_index) |-> se_state_index == (($past(se_state_index) == SE_LAST_STATE)
      ? 6'h00 : $past(se_state_index) + 6'h01);
  endproperty
  a_idx: assert property (p_idx) else $error("bad state step");
  c_nack: cover property (bus_start && !download_done);
  c_rd: cover property (bus_rd_valid);
  c_idx: cover property ($changed(se_state_index));
endmodule

bind config_download_update_ctrl cfg_loader_asserts chk (.clk(clk), .rst(rst),
  .supply_ok(supply_ok), .bus_start(bus_start), .bus_rd_req(bus_rd_req),
  .bus_ack_valid(bus_ack_valid), .bus_ack(bus_ack), .bus_rd_valid(bus_rd_valid),
  .download_done(download_done), .active_cfg(active_cfg), .se_state_index(se_state_index));

/* File: verif/host_model.sv */
// Serial bus host model that drives the byte front end of the controller.
// Strobes change just after a rising edge and answers are taken a cycle later.
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic bus_start,
  output logic bus_wbyte_valid,
  output logic [7:0] bus_wbyte,
  output logic bus_rd_req,
  input wire logic bus_ack_valid,
  input wire logic bus_ack,
  input wire logic bus_rd_valid,
  input wire logic [7:0] bus_rdata
);
  initial begin
    bus_start = 1'b0;
    bus_wbyte_valid = 1'b0;
    bus_wbyte = 8'h00;
    bus_rd_req = 1'b0;
  end

  // The data lines show the inverse once released, so stale bytes are never reused.
  task automatic step(input int kind, input logic [7:0] b, output logic a);
    @(posedge clk);
    bus_start <= (kind == 0);
    bus_wbyte_valid <= (kind == 1);
    bus_wbyte <= b;
    @(posedge clk);
    bus_start <= 1'b0;
    bus_wbyte_valid <= 1'b0;
    bus_wbyte <= ~b;
    #1;
    a = bus_ack_valid & bus_ack;
  endtask

  task automatic wr(input logic [7:0] q[$], output logic a);
    logic x;
    step(0, 8'h00, a);
    foreach (q[i]) begin
      step(1, q[i], x);
      a = a & x;
    end
  endtask

  task automatic rd(output logic [7:0] d);
    @(posedge clk);
    bus_rd_req <= 1'b1;
    @(posedge clk);
    bus_rd_req <= 1'b0;
    d = 8'hxx;
    for (int i = 0; i < 3; i++) begin
      #1;
      if (bus_rd_valid === 1'b1) begin
        d = bus_rdata;
        break;
      end
      @(posedge clk);
    end
  endtask
endmodule

/* File: verif/config_download_update_ctrl_tb.sv */
// Self-checking bench for the configuration download and update controller.
// Uses host_model as the bus master and a short engine delay.
`timescale 1ns/1ps
module config_download_update_ctrl_tb
  import cfg_loader_pkg::*;
;
  logic clk, rst, supply_ok, se_advance, bus_start, bus_wbyte_valid, bus_rd_req;
  logic bus_ack_valid, bus_ack, bus_rd_valid, download_done, a;
  logic [7:0] bus_wbyte, bus_rdata, d;
  logic [CFG_BYTES*8-1:0] active_cfg;
  logic [63:0] se_state_word;
  logic [5:0] se_state_index;
  int err_count = 0;
  int tests_run = 0;

  config_download_update_ctrl #(.SE_DELAY_CYCLES(20)) DUT (.clk(clk), .rst(rst),
    .supply_ok(supply_ok), .bus_start(bus_start), .bus_wbyte_valid(bus_wbyte_valid),
    .bus_wbyte(bus_wbyte), .bus_rd_req(bus_rd_req), .se_advance(se_advance),
    .bus_ack_valid(bus_ack_valid), .bus_ack(bus_ack), .bus_rd_valid(bus_rd_valid),
    .bus_rdata(bus_rdata), .download_done(download_done), .active_cfg(active_cfg),
    .se_state_word(se_state_word), .se_state_index(se_state_index));
  host_model host (.clk(clk), .bus_start(bus_start), .bus_wbyte_valid(bus_wbyte_valid),
    .bus_wbyte(bus_wbyte), .bus_rd_req(bus_rd_req), .bus_ack_valid(bus_ack_valid),
    .bus_ack(bus_ack), .bus_rd_valid(bus_rd_valid), .bus_rdata(bus_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string n, input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [7:0] act(input int k);
    return active_cfg[8*k +: 8];
  endfunction

  task automatic rd(input logic [7:0] p, input logic [7:0] lo, input bit st);
    if (st) host.wr('{p, lo}, a);
    else host.wr('{p}, a);
    host.rd(d);
  endtask

  task automatic t_early();
    host.wr('{8'h10, 8'h01}, a);
    check("early ack", a, 0);
    cyc(300);
    check("done w/o supply", download_done, 0);
  endtask

  task automatic t_powerup();
    @(posedge clk);
    supply_ok <= 1'b1;
    for (int i = 0; i < 2000 && download_done !== 1'b1; i++) @(posedge clk);
    check("download done", download_done, 1);
    if (download_done !== 1'b1) complete_run();
    cyc(1100);
  endtask

  task automatic t_staged();
    host.wr('{8'h90, 8'h01}, a);
    check("ack", a, 1);
    host.wr('{8'h10, 8'h11}, a);
    cyc(1);
    check("open write", act(8'h10), 8'h11);
    host.wr('{8'h90, 8'h00}, a);
    host.wr('{8'h10, 8'h5a}, a);
    cyc(2);
    check("staged held", act(8'h10), 8'h11);
    rd(8'h10, 0, 0);
    check("first side", d, 8'h5a);
    host.wr('{8'h90, 8'h02}, a);
    cyc(3);
    check("update pulse", act(8'h10), 8'h5a);
    rd(8'h90, 0, 0);
    check("pulse bit", d[1], 0);
  endtask

  task automatic t_reload();
    host.wr('{8'h90, 8'h01}, a);
    host.wr('{8'h12, 8'h33}, a);
    host.wr('{8'hf8, 8'h12, 8'h5e}, a);
    cyc(4);
    check("nv no effect", act(8'h12), 8'h33);
    host.wr('{8'hd8, 8'h01}, a);
    cyc(300);
    check("reload", act(8'h12), 8'h5e);
  endtask

  task automatic t_erase();
    host.wr('{8'hf9, 8'h00, 8'h3c}, a);
    cyc(4);
    for (int e = 0; e < 2; e++) begin
      host.wr('{8'h90, (e == 1) ? 8'h04 : 8'h00}, a);
      host.wr('{8'hf9, 8'h00}, a);
      host.wr('{8'hfe}, a);
      cyc(40);
      rd(8'hf9, 8'h00, 1);
      check("erase", d, (e == 1) ? 8'hff : 8'h3c);
    end
  endtask

  task automatic t_engine();
    for (int i = 0; i < 8; i++) begin
      host.wr('{8'hfa, 8'(8 + i), 8'(8'h10 + i)}, a);
      cyc(4);
    end
    @(posedge clk);
    se_advance <= 1'b1;
    @(posedge clk);
    se_advance <= 1'b0;
    cyc(1010);
    check("state index", se_state_index, 1);
    check("state word", se_state_word, 64'h1716151413121110);
  endtask

  initial begin
    rst = 1'b1;
    supply_ok = 1'b0;
    se_advance = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_early();
    t_powerup();
    t_staged();
    t_reload();
    t_erase();
    t_engine();
    complete_run();
  end
endmodule
